/* rtl/dpls_regs.vh */
`ifndef DPLS_REGS_VH
`define DPLS_REGS_VH

// register addresses
`define DPLS_ADDR_CTRL      8'h00
`define DPLS_ADDR_WIN       8'h01
`define DPLS_ADDR_LANE_EN   8'h02
`define DPLS_ADDR_IN_EN     8'h03
`define DPLS_ADDR_STATUS    8'h04
`define DPLS_ADDR_LEVEL     8'h1C

// control register fields
`define DPLS_CTRL_DUAL      0
`define DPLS_CTRL_FMT_LO    1
`define DPLS_CTRL_FMT_HI    2
`define DPLS_CTRL_STROBE    3
`define DPLS_CTRL_W         4

// color formats
`define DPLS_FMT_30         2'h0
`define DPLS_FMT_24         2'h1
`define DPLS_FMT_18         2'h2
`define DPLS_MASK_30        10'h3FF
`define DPLS_MASK_24        10'h3FC
`define DPLS_MASK_18        10'h3F0

// level register fields
`define DPLS_LVL_EVEN_SWING 5
`define DPLS_LVL_ODD_SWING  4
`define DPLS_LVL_EVEN_OFS   3:2
`define DPLS_LVL_ODD_OFS    1:0
`define DPLS_LVL_W          6

// status register fields
`define DPLS_STAT_OVF       15
`define DPLS_STAT_EDGE      14

// reset values
`define DPLS_CTRL_RST       4'h0
`define DPLS_WIN_RST        2'h0
`define DPLS_LANE_EN_RST    12'hFFF
`define DPLS_IN_EN_RST      2'h3
`define DPLS_LEVEL_RST      6'h00

// framing
`define DPLS_FRAME_BITS     7
`define DPLS_FRAME_LAST     3'h6
`define DPLS_CLK_PATTERN    7'h63

`endif

/* rtl/dpls_fifo.v */
`timescale 1ns/1ps
module dpls_fifo #(
  parameter WIDTH = 70,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             sys_clk_i,
  input  wire             rst_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  output wire [AW:0]      count_o
);
  localparam [31:0] DEPTH_W = DEPTH;
  localparam [31:0] LAST_W  = DEPTH - 1;
  localparam [AW:0] FULL    = DEPTH_W[AW:0];

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  wire            push;
  wire            pop;
  wire [AW-1:0]   last_ptr;

  assign last_ptr    = LAST_W[AW-1:0];
  assign in_ready_o  = (count_r != FULL);
  assign out_valid_o = (count_r != {(AW+1){1'b0}});
  assign out_data_o  = mem_r[rd_ptr_r];
  assign count_o     = count_r;
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge sys_clk_i)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data_i;
  end

  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_r <= (wr_ptr_r == last_ptr) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= (rd_ptr_r == last_ptr) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      if (push & ~pop)
        count_r <= count_r + 1'b1;
      else if (pop & ~push)
        count_r <= count_r - 1'b1;
    end
  end
endmodule // dpls_fifo

/* rtl/dpls_lane_ser.v */
`timescale 1ns/1ps
module dpls_lane_ser #(
  parameter LANES = 6,
  parameter BITS  = 7
) (
  input  wire                  sys_clk_i,
  input  wire                  rst_i,
  input  wire                  load_i,
  input  wire [LANES*BITS-1:0] word_i,
  output wire [LANES-1:0]      lane_o
);
  genvar l;
  generate
    for (l = 0; l < LANES; l = l + 1)
    begin : g_lane
      reg [BITS-1:0] sh_r;
      // msb first, one bit per clock
      always @(posedge sys_clk_i or posedge rst_i)
      begin
        if (rst_i)
          sh_r <= {BITS{1'b0}};
        else if (load_i)
          sh_r <= word_i[l*BITS +: BITS];
        else
          sh_r <= {sh_r[BITS-2:0], 1'b0};
      end
      assign lane_o[l] = sh_r[BITS-1];
    end
  endgenerate
endmodule // dpls_lane_ser

/* rtl/dpls_top.v */
`timescale 1ns/1ps
`include "dpls_regs.vh"
module dpls_top #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW    = 3,
  parameter AW         = 8,
  parameter DW         = 16
) (
  input  wire          sys_clk_i,
  input  wire          rst_i,
  input  wire          pixel_clock_input_i,
  input  wire          capture_edge_select_i,
  input  wire [29:0]   rgb_a_i,
  input  wire [29:0]   rgb_b_i,
  input  wire          hsync_i,
  input  wire          vsync_i,
  input  wire          pixel_valid_i,
  input  wire [1:0]    user_i,
  input  wire [AW-1:0] addr_i,
  input  wire [DW-1:0] wr_data_i,
  input  wire          wr_i,
  input  wire          rd_i,
  output wire [DW-1:0] rd_data_o,
  output wire [4:0]    odd_lane_o,
  output wire          odd_clk_lane_o,
  output wire [4:0]    even_lane_o,
  output wire          even_clk_lane_o,
  output wire [2:0]    odd_bank_level_bits_o,
  output wire [2:0]    even_bank_level_bits_o
);
  localparam IN_W   = 67;
  localparam DATA_W = 65;
  localparam BANK_W = 35;
  localparam WORD_W = 70;
  localparam LANES  = 6;
  localparam SER_W  = LANES * `DPLS_FRAME_BITS;

  // input synchronisers
  reg  [IN_W-1:0]   in_s1_r;
  reg  [IN_W-1:0]   in_s2_r;
  wire [IN_W-1:0]   in_raw;
  // sampling window delay line
  reg  [DATA_W-1:0] win_d1_r;
  reg  [DATA_W-1:0] win_d2_r;
  reg  [DATA_W-1:0] win_d3_r;
  reg  [DATA_W-1:0] win_data;
  reg               clk_d_r;
  wire              clk_s;
  wire              edge_sel;
  wire              rise;
  wire              fall;
  wire              cap_edge;
  wire              other_edge;
  // registers
  reg  [`DPLS_CTRL_W-1:0] ctrl_r;
  reg  [1:0]              win_r;
  reg  [11:0]             lane_en_r;
  reg  [1:0]              in_en_r;
  reg  [`DPLS_LVL_W-1:0]  level_r;
  reg                     ovf_r;
  reg                     edge_seen_r;
  reg  [DW-1:0]           rd_data_r;
  reg  [DW-1:0]           rd_nxt;
  // capture path
  reg  [4:0]        ctrl_hold_r;
  wire [4:0]        ctrl_use;
  reg  [9:0]        fmt_mask;
  wire [29:0]       mask30;
  wire [29:0]       pix_a;
  wire [29:0]       pix_b;
  reg  [WORD_W-1:0] push_data_r;
  reg               push_valid_r;
  wire              fifo_in_ready;
  wire              fifo_out_valid;
  wire [WORD_W-1:0] fifo_out_data;
  wire [FIFO_AW:0]  fifo_count;
  // frame path
  reg  [2:0]        frame_cnt_r;
  wire              frame_load;
  wire [WORD_W-1:0] frame_word;
  wire [SER_W-1:0]  odd_word;
  wire [SER_W-1:0]  even_word;
  wire [SER_W-1:0]  odd_gated;
  wire [SER_W-1:0]  even_gated;
  wire [LANES-1:0]  odd_ser;
  wire [LANES-1:0]  even_ser;
  wire              ovf_set;
  wire              ovf_clr;

  assign in_raw = {capture_edge_select_i, pixel_clock_input_i, user_i, pixel_valid_i,
                   vsync_i, hsync_i, rgb_b_i, rgb_a_i};

  // two-stage synchroniser on every pin except the register bus
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      in_s1_r <= {IN_W{1'b0}};
      in_s2_r <= {IN_W{1'b0}};
      clk_d_r <= 1'b0;
    end
    else
    begin
      in_s1_r <= in_raw;
      in_s2_r <= in_s1_r;
      clk_d_r <= clk_s;
    end
  end

  assign clk_s      = in_s2_r[65];
  assign edge_sel   = in_s2_r[66];
  assign rise       = clk_s & ~clk_d_r;
  assign fall       = ~clk_s & clk_d_r;
  assign cap_edge   = edge_sel ? fall : rise;
  assign other_edge = edge_sel ? rise : fall;

  // window shift: data taken 0..3 cycles behind the detected edge
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      win_d1_r <= {DATA_W{1'b0}};
      win_d2_r <= {DATA_W{1'b0}};
      win_d3_r <= {DATA_W{1'b0}};
    end
    else
    begin
      win_d1_r <= in_s2_r[DATA_W-1:0];
      win_d2_r <= win_d1_r;
      win_d3_r <= win_d2_r;
    end
  end

  always @*
  begin
    case (win_r)
      2'h0:    win_data = in_s2_r[DATA_W-1:0];
      2'h1:    win_data = win_d1_r;
      2'h2:    win_data = win_d2_r;
      default: win_data = win_d3_r;
    endcase
  end

  // control strobe: same edge or opposite edge
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      ctrl_hold_r <= 5'h00;
    else if (other_edge)
      ctrl_hold_r <= win_data[64:60];
  end

  assign ctrl_use = ctrl_r[`DPLS_CTRL_STROBE] ? ctrl_hold_r : win_data[64:60];

  always @*
  begin
    case (ctrl_r[`DPLS_CTRL_FMT_HI:`DPLS_CTRL_FMT_LO])
      `DPLS_FMT_24: fmt_mask = `DPLS_MASK_24;
      `DPLS_FMT_18: fmt_mask = `DPLS_MASK_18;
      default:      fmt_mask = `DPLS_MASK_30;
    endcase
  end

  assign mask30 = {3{fmt_mask}};
  assign pix_a  = in_en_r[0] ? (win_data[29:0] & mask30) : 30'h00000000;
  assign pix_b  = (in_en_r[1] & ctrl_r[`DPLS_CTRL_DUAL]) ?
                  (win_data[59:30] & mask30) : 30'h00000000;

  // one word per captured pixel clock edge
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      push_data_r  <= {WORD_W{1'b0}};
      push_valid_r <= 1'b0;
    end
    else
    begin
      push_valid_r <= cap_edge;
      if (cap_edge)
        push_data_r <= {ctrl_use, pix_b, ctrl_use, pix_a};
    end
  end

  dpls_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push_valid_r),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (push_data_r),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (frame_load),
    .out_data_o  (fifo_out_data),
    .count_o     (fifo_count)
  );

  // seven-state frame counter
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      frame_cnt_r <= 3'h0;
    else if (frame_load)
      frame_cnt_r <= 3'h0;
    else
      frame_cnt_r <= frame_cnt_r + 3'h1;
  end

  assign frame_load = (frame_cnt_r == `DPLS_FRAME_LAST);
  assign frame_word = fifo_out_valid ? fifo_out_data : {WORD_W{1'b0}};
  assign odd_word   = {`DPLS_CLK_PATTERN, frame_word[BANK_W-1:0]};
  assign even_word  = {`DPLS_CLK_PATTERN, frame_word[WORD_W-1:BANK_W]};

  // per-lane output enables
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1)
    begin : g_gate
      assign odd_gated[g*`DPLS_FRAME_BITS +: `DPLS_FRAME_BITS] =
        odd_word[g*`DPLS_FRAME_BITS +: `DPLS_FRAME_BITS] &
        {`DPLS_FRAME_BITS{lane_en_r[g]}};
      assign even_gated[g*`DPLS_FRAME_BITS +: `DPLS_FRAME_BITS] =
        even_word[g*`DPLS_FRAME_BITS +: `DPLS_FRAME_BITS] &
        {`DPLS_FRAME_BITS{lane_en_r[g+LANES]}};
    end
  endgenerate

  dpls_lane_ser #(
    .LANES (LANES),
    .BITS  (`DPLS_FRAME_BITS)
  ) u_odd_ser (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .load_i    (frame_load),
    .word_i    (odd_gated),
    .lane_o    (odd_ser)
  );

  dpls_lane_ser #(
    .LANES (LANES),
    .BITS  (`DPLS_FRAME_BITS)
  ) u_even_ser (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .load_i    (frame_load),
    .word_i    (even_gated),
    .lane_o    (even_ser)
  );

  assign odd_lane_o      = odd_ser[4:0];
  assign odd_clk_lane_o  = odd_ser[5];
  assign even_lane_o     = even_ser[4:0];
  assign even_clk_lane_o = even_ser[5];

  // register file
  assign ovf_set = push_valid_r & ~fifo_in_ready;
  assign ovf_clr = wr_i & (addr_i == `DPLS_ADDR_STATUS) & wr_data_i[`DPLS_STAT_OVF];

  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_r      <= `DPLS_CTRL_RST;
      win_r       <= `DPLS_WIN_RST;
      lane_en_r   <= `DPLS_LANE_EN_RST;
      in_en_r     <= `DPLS_IN_EN_RST;
      level_r     <= `DPLS_LEVEL_RST;
      ovf_r       <= 1'b0;
      edge_seen_r <= 1'b0;
      rd_data_r   <= {DW{1'b0}};
    end
    else
    begin
      if (wr_i)
      begin
        case (addr_i)
          `DPLS_ADDR_CTRL:    ctrl_r    <= wr_data_i[`DPLS_CTRL_W-1:0];
          `DPLS_ADDR_WIN:     win_r     <= wr_data_i[1:0];
          `DPLS_ADDR_LANE_EN: lane_en_r <= wr_data_i[11:0];
          `DPLS_ADDR_IN_EN:   in_en_r   <= wr_data_i[1:0];
          `DPLS_ADDR_LEVEL:   level_r   <= wr_data_i[`DPLS_LVL_W-1:0];
          default:            ;
        endcase
      end
      // set wins over clear
      if (ovf_set)
        ovf_r <= 1'b1;
      else if (ovf_clr)
        ovf_r <= 1'b0;
      if (cap_edge)
        edge_seen_r <= 1'b1;
      rd_data_r <= rd_nxt;
    end
  end

  always @*
  begin
    rd_nxt = {DW{1'b0}};
    if (rd_i)
    begin
      case (addr_i)
        `DPLS_ADDR_CTRL:    rd_nxt[`DPLS_CTRL_W-1:0] = ctrl_r;
        `DPLS_ADDR_WIN:     rd_nxt[1:0] = win_r;
        `DPLS_ADDR_LANE_EN: rd_nxt[11:0] = lane_en_r;
        `DPLS_ADDR_IN_EN:   rd_nxt[1:0] = in_en_r;
        `DPLS_ADDR_LEVEL:   rd_nxt[`DPLS_LVL_W-1:0] = level_r;
        `DPLS_ADDR_STATUS:
        begin
          rd_nxt[`DPLS_STAT_OVF]  = ovf_r;
          rd_nxt[`DPLS_STAT_EDGE] = edge_seen_r;
          rd_nxt[FIFO_AW:0]       = fifo_count;
        end
        default:            rd_nxt = {DW{1'b0}};
      endcase
    end
  end

  assign rd_data_o = rd_data_r;

  // lane level controls: {swing, offset[1:0]}
  assign odd_bank_level_bits_o  = {level_r[`DPLS_LVL_ODD_SWING],
                                   level_r[`DPLS_LVL_ODD_OFS]};
  assign even_bank_level_bits_o = {level_r[`DPLS_LVL_EVEN_SWING],
                                   level_r[`DPLS_LVL_EVEN_OFS]};

  // clock range: edge detection needs no fixed pixel rate
endmodule // dpls_top

/* test/dpls_top_monitor.sv */
`timescale 1ns/1ps
module dpls_top_monitor #(
  parameter AW = 8,
  parameter DW = 16
) (
  input wire          sys_clk_i,
  input wire          rst_i,
  input wire [AW-1:0] addr_i,
  input wire [DW-1:0] wr_data_i,
  input wire          wr_i,
  input wire          rd_i,
  input wire [DW-1:0] rd_data_o,
  input wire [4:0]    odd_lane_o,
  input wire          odd_clk_lane_o,
  input wire [4:0]    even_lane_o,
  input wire          even_clk_lane_o,
  input wire [2:0]    odd_bank_level_bits_o,
  input wire [2:0]    even_bank_level_bits_o
);
  reg        dual_r;
  reg [11:0] en_r;
  reg [3:0]  since_r;
  wire [5:0] lvl = {even_bank_level_bits_o[2], odd_bank_level_bits_o[2],
                    even_bank_level_bits_o[1:0], odd_bank_level_bits_o[1:0]};
  wire [5:0] wd  = wr_data_i[5:0];
  // lanes off once a whole frame has passed since the enable write
  wire [11:0] off = since_r[3] ? ~en_r : 12'h000;
  always @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      dual_r <= 1'b0;
      en_r   <= 12'hFFF;
      since_r <= 4'h0;
    end
    else
    begin
      if (wr_i && addr_i == 8'h00)
        dual_r <= wr_data_i[0];
      if (wr_i && addr_i == 8'h02)
      begin
        en_r    <= wr_data_i[11:0];
        since_r <= 4'h0;
      end
      else if (!since_r[3])
        since_r <= since_r + 4'h1;
    end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  property p_rd_quiet;
    !$past(rd_i) |-> rd_data_o == 16'h0000;
  endproperty
  property p_lvl_write;
    wr_i && addr_i == 8'h1C |=> lvl == $past(wd);
  endproperty
  property p_lvl_hold;
    !(wr_i && addr_i == 8'h1C) |=> $stable(lvl);
  endproperty
  property p_lvl_read;
    rd_i && addr_i == 8'h1C |=> rd_data_o == {10'h000, $past(lvl)};
  endproperty
  property p_en_read;
    rd_i && addr_i == 8'h02 |=> rd_data_o == {4'h0, $past(en_r)};
  endproperty
  property p_clk_shape;
    $fell(odd_clk_lane_o) |-> !odd_clk_lane_o [*3] ##1 odd_clk_lane_o [*4];
  endproperty
  property p_clk_pair;
    odd_clk_lane_o == even_clk_lane_o;
  endproperty
  property p_lane_off;
    (odd_lane_o & off[4:0]) == 5'h00 && (even_lane_o & off[10:6]) == 5'h00;
  endproperty
  property p_single_even;
    !dual_r |-> even_lane_o[3:0] == 4'h0;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data not idle");
  a_lvl_write: assert property (p_lvl_write) else $error("level bits wrong");
  a_lvl_hold: assert property (p_lvl_hold) else $error("level bits moved");
  a_lvl_read: assert property (p_lvl_read) else $error("level readback");
  a_en_read: assert property (p_en_read) else $error("enable readback");
  a_clk_shape: assert property (p_clk_shape) else $error("clock lane shape");
  a_clk_pair: assert property (p_clk_pair) else $error("clock lanes differ");
  a_lane_off: assert property (p_lane_off) else $error("disabled lane active");
  a_single_even: assert property (p_single_even) else $error("even rgb in single");
  c_lvl_read: cover property (rd_i && addr_i == 8'h1C);
  c_frame: cover property ($fell(odd_clk_lane_o));
  c_dual: cover property (dual_r && even_lane_o != 5'h00);
endmodule // dpls_top_monitor

/* test/dpls_src_model.sv */
`timescale 1ns/1ps
module dpls_src_model (
  input  wire        run_i,
  input  wire        edge_i,
  output reg         pclk_o,
  output reg  [29:0] rgb_a_o,
  output reg  [29:0] rgb_b_o,
  output reg  [4:0]  ctl_o,
  output reg  [9:0]  n_o
);
  reg [9:0] p;
  initial
  begin
    pclk_o  = 1'b0;
    rgb_a_o = 30'h0;
    rgb_b_o = 30'h0;
    ctl_o   = 5'h00;
    n_o     = 10'h000;
  end
  // next pixel, held a whole period
  task automatic put;
    p       = 10'h2C7 + n_o * 10'h0D3;
    rgb_a_o = {3{p}};
    rgb_b_o = {3{~p}};
    ctl_o   = {p[3:2], 1'b1, p[1:0]};
    n_o     = n_o + 10'h001;
  endtask
  // 8 MHz clock only in bursts, launch on the edge opposite capture
  always
  begin
    wait (run_i);
    if (!edge_i) put;
    #62.5 pclk_o = 1'b1;
    if (edge_i) put;
    #62.5 pclk_o = 1'b0;
  end
endmodule // dpls_src_model

/* test/test_dpls_top.sv */
`timescale 1ns/1ps
module test_dpls_top;
  logic        sys_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        edge_sel  = 1'b0;
  logic        run       = 1'b0;
  logic [7:0]  addr_i    = 8'h00;
  logic [15:0] wr_data_i = 16'h0000;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  wire  [15:0] rd_data_o;
  wire  [4:0]  odd_lane_o;
  wire  [4:0]  even_lane_o;
  wire         odd_clk_lane_o;
  wire         even_clk_lane_o;
  wire  [2:0]  odd_bank_level_bits_o;
  wire  [2:0]  even_bank_level_bits_o;
  wire         pclk;
  wire  [29:0] rgb_a;
  wire  [29:0] rgb_b;
  wire  [4:0]  ctl;
  wire  [9:0]  pix_n;
  int          error_cnt   = 0;
  int          checks_done = 0;
  logic [69:0] rxq[$];
  logic [6:0]  sh[12];
  initial
    forever #4 sys_clk_i = ~sys_clk_i;
  dpls_top u_dpls_top (
    .sys_clk_i, .rst_i, .pixel_clock_input_i(pclk), .capture_edge_select_i(edge_sel),
    .rgb_a_i(rgb_a), .rgb_b_i(rgb_b), .hsync_i(ctl[0]), .vsync_i(ctl[1]),
    .pixel_valid_i(ctl[2]), .user_i(ctl[4:3]), .addr_i, .wr_data_i, .wr_i, .rd_i,
    .rd_data_o, .odd_lane_o, .odd_clk_lane_o, .even_lane_o, .even_clk_lane_o,
    .odd_bank_level_bits_o, .even_bank_level_bits_o
  );
  dpls_src_model u_dpls_src_model (
    .run_i(run), .edge_i(edge_sel), .pclk_o(pclk), .rgb_a_o(rgb_a), .rgb_b_o(rgb_b),
    .ctl_o(ctl), .n_o(pix_n)
  );
  // receiver: frame ends when clock lane shows 1100011
  always @(posedge sys_clk_i)
  begin : rx
    logic [69:0] w;
    for (int k = 0; k < 6; k++)
    begin
      sh[k]     = {sh[k][5:0], k < 5 ? odd_lane_o[k] : odd_clk_lane_o};
      sh[k + 6] = {sh[k + 6][5:0], k < 5 ? even_lane_o[k] : even_clk_lane_o};
    end
    if (sh[5] === 7'h63)
    begin
      for (int k = 0; k < 5; k++)
      begin
        w[7 * k +: 7]      = sh[k];
        w[35 + 7 * k +: 7] = sh[k + 6];
      end
      if (w[32] === 1'b1)
        rxq.push_back(w);
    end
  end
  task automatic cmp(input logic [69:0] got, input logic [69:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    addr_i    <= a;
    wr_data_i <= d;
    wr_i      <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 d = rd_data_o;
    @(posedge sys_clk_i);
    cmp(d, e);
  endtask
  // n: pixel index of the rgb data, c: pixel index of the controls
  function automatic logic [69:0] expw(input logic [9:0] n, input logic [9:0] c,
                                       input logic d, input logic [1:0] f,
                                       input logic [1:0] ie, input logic [4:0] en);
    logic [9:0]  p;
    logic [9:0]  q;
    logic [9:0]  m;
    logic [34:0] o;
    p = 10'h2C7 + n * 10'h0D3;
    q = 10'h2C7 + c * 10'h0D3;
    m = f == 2'h1 ? 10'h3FC : f == 2'h2 ? 10'h3F0 : 10'h3FF;
    o = {q[3:2], 1'b1, q[1:0], (ie[0] ? {3{p & m}} : 30'h0)};
    for (int k = 0; k < 5; k++)
      if (!en[k])
        o[7 * k +: 7] = 7'h00;
    return {q[3:2], 1'b1, q[1:0], ((d & ie[1]) ? {3{~p & m}} : 30'h0), o};
  endfunction
  task automatic t_regs;
    logic [7:0]  a[7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h1C, 8'h10};
    logic [15:0] v[7] = '{16'h0, 16'h0, 16'h0FFF, 16'h0003, 16'h0, 16'h0, 16'h0};
    for (int i = 0; i < 7; i++)
      rchk(a[i], v[i]);
    wr(8'h01, 16'hFFFF);
    rchk(8'h01, 16'h0003);
  endtask
  task automatic t_level;
    logic [15:0] v[3] = '{16'hFFFF, 16'h0029, 16'h0016};
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h1C, v[i]);
      rchk(8'h1C, v[i] & 16'h003F);
      cmp({even_bank_level_bits_o, odd_bank_level_bits_o},
          {v[i][5], v[i][3:2], v[i][4], v[i][1:0]});
    end
  endtask
  task automatic t_stream(input logic d, input logic [1:0] f, input logic e, input logic s,
                          input logic [1:0] w, input logic [1:0] ie, input logic [4:0] en);
    logic [9:0] n0;
    wr(8'h02, {4'h0, 7'h7F, en});
    wr(8'h00, {12'h0, s, f, d});
    wr(8'h01, {14'h0, w});
    wr(8'h03, {14'h0, ie});
    edge_sel <= e;
    rxq.delete();
    n0 = pix_n;
    run <= 1'b1;
    repeat (100) @(posedge sys_clk_i);
    run <= 1'b0;
    repeat (80) @(posedge sys_clk_i);
    cmp(rxq.size(), pix_n - n0);
    foreach (rxq[i])
      cmp(rxq[i], expw(10'(n0 + i), 10'(n0 + i - s), d, f, ie, en));
  endtask
  task automatic report_and_stop;
    $display("errors %0d, checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    error_cnt++;
    report_and_stop;
  end
  initial
  begin
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    t_regs;
    t_level;
    t_stream(1'b0, 2'h0, 1'b0, 1'b0, 2'h0, 2'h3, 5'h1F);
    t_stream(1'b1, 2'h1, 1'b1, 1'b0, 2'h1, 2'h3, 5'h1F);
    t_stream(1'b1, 2'h2, 1'b0, 1'b0, 2'h2, 2'h1, 5'h1E);
    t_stream(1'b0, 2'h3, 1'b1, 1'b1, 2'h3, 2'h3, 5'h1F);
    rchk(8'h04, 16'h4000);
    report_and_stop;
  end
endmodule // test_dpls_top
bind dpls_top dpls_top_monitor #(.AW(AW), .DW(DW)) u_dpls_top_monitor (
  .sys_clk_i, .rst_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .odd_lane_o,
  .odd_clk_lane_o, .even_lane_o, .even_clk_lane_o, .odd_bank_level_bits_o,
  .even_bank_level_bits_o
);
